// >>> logic/spm_port.sv
// Serial port in SPI mode: master with four clock rates or slave on an
// external clock, with a small byte-wide register port.
// Assumes every input is synchronous to clk, including the serial clock pin
// in slave mode, and that the pad logic resolves the wires from the enables.
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Open drain select: outputs only pull low.
// - Shift on programmed edge, capture on opposite.
// - Master write to buffer starts transfer.
// - Input still sampled when output pin input.
// - Bytes move most significant bit first.
// - Master rate: divide 4, 16, 64, timer.
// - Edge select set: first bit before edge.
// - Slave shifts on external clock, flags eighth.
// - Select mode: transfer and drive only low.
// - Select rising releases output at once.
// - Select high or disable clears bit counter.
// - Output pin input means no transmit.
// - Sleep freezes master transfer, then resumes.
// - Enabled interrupt on completion wakes device.
// - Slave keeps receiving in power modes.
// - Reset disables port and aborts transfer.
// - Standard modes map to polarity, edge.
// - Sample phase picks input sample moment.
// - Buffer write while busy sets collision.
// - Byte received sets full; read clears.
module spm_port (
   // Clock and reset.
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   // Register port.
   input  wire logic [spm_pkg::ADDR_W-1:0] addr,
   input  wire logic [7:0]               wdata,
   input  wire logic                     wr_strobe,
   input  wire logic                     rd_strobe,
   output logic      [7:0]               rdata,
   // Serial pins.
   input  wire logic                     serial_in_pin,
   output logic                          serial_out_pin,
   output logic                          serial_out_pin_oe,
   input  wire logic                     serial_clk_in,
   output logic                          serial_clk_out,
   output logic                          serial_clk_oe,
   input  wire logic                     select_n,
   // System side.
   input  wire logic                     sleep_mode,
   input  wire logic                     timer2_tick,
   output logic                          wake_req
);
   import spm_pkg::*;

   // ----------------------------------------------------------------------
   // Registers.
   // ----------------------------------------------------------------------
   logic [7:0]  data_buffer_reg;
   logic [7:0]  shift_register_reg;
   logic [7:0]  tx_shift_reg;
   logic        out_bit_reg;
   logic        sck_reg;
   logic        sck_prev_reg;
   logic [5:0]  control_one_reg;
   logic        write_collision_flag_reg;
   logic        sample_phase_reg;
   logic        edge_sel_reg;
   logic        buffer_full_flag_reg;
   logic [7:0]  port_g_direction_reg;
   logic        port_irq_flag_reg;
   logic        irq_en_reg;
   spm_state_t  state_reg;
   logic [4:0]  slot_reg;
   logic [5:0]  half_reg;
   logic [2:0]  bcnt_reg;
   logic [7:0]  rdata_reg;
   logic        sdo_reg;
   logic        sdo_oe_reg;
   logic        sck_o_reg;
   logic        sck_oe_reg;
   logic        wake_reg;

   // ----------------------------------------------------------------------
   // Mode decode.
   // ----------------------------------------------------------------------
   function automatic logic [5:0] spm_half_len(input logic [3:0] m);
      logic [5:0] h;
      h = HALF_A;
      if (m == MODE_DIV16) begin
         h = HALF_B;
      end else if (m == MODE_DIV64) begin
         h = HALF_C;
      end
      return h;
   endfunction

   // Configuration fields and the port level decisions drawn from them.
   wire       port_enable_bit = control_one_reg[CTL_EN];
   wire       clock_idle_polarity             = control_one_reg[CTL_CKP];
   wire [3:0] mode_field      = control_one_reg[3:0];
   wire       is_master       = port_enable_bit && (mode_field <= MODE_TMR2);
   wire       is_slave        = port_enable_bit && (mode_field == MODE_SLV_SS || mode_field == MODE_SLV);
   wire       ss_block        = (mode_field == MODE_SLV_SS) && select_n;
   wire       port_reset      = !port_enable_bit || (is_slave && ss_block);
   wire       od              = port_g_direction_reg[PG_OD];
   wire       running         = (state_reg == SPM_RUN);
   wire       busy            = is_master ? running : (bcnt_reg != 3'h0);

   // Register port decode.
   wire buf_wr     = wr_strobe && (addr == OFF_DATA_BUFFER);
   wire buf_rd     = rd_strobe && (addr == OFF_DATA_BUFFER);
   wire ctl_wr     = wr_strobe && (addr == OFF_CONTROL_ONE);
   wire sta_wr     = wr_strobe && (addr == OFF_STATUS_WORD);
   wire pg_wr      = wr_strobe && (addr == OFF_PORT_G_DIR);
   wire irq_wr     = wr_strobe && (addr == OFF_IRQ_CONTROL);
   wire write_collision_flag_set   = buf_wr && busy;
   wire load       = buf_wr && !busy;
   wire start      = load && is_master;

   // ----------------------------------------------------------------------
   // Master edge sequencer: seventeen slots, sixteen of which toggle the
   // clock; the last one ends the byte and, with edge select clear, also takes the late sample.
   // ----------------------------------------------------------------------
   wire [5:0] half_len  = spm_half_len(mode_field);
   wire       rate_hit  = (mode_field == MODE_TMR2) ? timer2_tick : (half_reg == half_len - 6'h01);
   wire       tick      = is_master && running && !sleep_mode && rate_hit;
   wire       last_slot = (slot_reg == LAST_SLOT);
   wire       cap_par   = !edge_sel_reg;
   // Output changes on trailing edges with edge select set, leading otherwise.
   wire       m_change  = tick && (edge_sel_reg ? (slot_reg[0] && slot_reg < 5'h0F)
                                                : (!slot_reg[0] && !last_slot));
   // A late sample phase moves each capture to the end of the bit time.
   wire       m_sample  = tick && (slot_reg[0] == (cap_par ^ sample_phase_reg))
                          && (sample_phase_reg ? (slot_reg != 5'h00) : !last_slot);
   wire       m_done    = tick && last_slot;

   // ----------------------------------------------------------------------
   // Slave edge detection on the externally supplied clock.
   // ----------------------------------------------------------------------
   wire s_go      = is_slave && !ss_block;
   wire s_edge    = (serial_clk_in != sck_prev_reg);
   wire s_lead    = s_edge && (serial_clk_in != clock_idle_polarity);
   wire s_trail   = s_edge && (serial_clk_in == clock_idle_polarity);
   wire s_change  = s_go && (edge_sel_reg ? (s_trail && bcnt_reg != 3'h0) : s_lead);
   wire s_cap     = s_go && (edge_sel_reg ? s_lead : s_trail);
   wire s_done    = s_cap && (bcnt_reg == LAST_BIT);

   // Merged shift events; sampling never looks at the output driver.
   wire       shift_ev = m_change || s_change;
   wire       samp_ev  = m_sample || s_cap;
   wire       done_ev  = m_done || s_done;
   wire [7:0] rx_next  = {shift_register_reg[6:0], serial_in_pin};
   wire [7:0] done_val = samp_ev ? rx_next : shift_register_reg;

   // Pin drive decisions; an output pin set as input never transmits.
   wire sdo_drive = port_enable_bit && !port_g_direction_reg[PG_SDO_DIR] && !ss_block;

   // Read multiplexer; unmapped offsets read as zero.
   wire [7:0] rd_mux =
      (addr == OFF_DATA_BUFFER) ? data_buffer_reg :
      (addr == OFF_CONTROL_ONE) ? {write_collision_flag_reg, 1'b0, control_one_reg} :
      (addr == OFF_STATUS_WORD) ? {sample_phase_reg, edge_sel_reg, 5'h00, buffer_full_flag_reg} :
      (addr == OFF_PORT_G_DIR)  ? port_g_direction_reg :
      (addr == OFF_IRQ_CONTROL) ? {6'h00, irq_en_reg, port_irq_flag_reg} : 8'h00;

   // ----------------------------------------------------------------------
   // Software visible registers. Hardware sets beat software clears.
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         control_one_reg          <= CTL_RST[5:0];
         write_collision_flag_reg <= CTL_RST[CTL_WRITE_COLLISION_FLAG];
         {sample_phase_reg, edge_sel_reg} <= STA_RST;
         port_g_direction_reg     <= PG_RST;
         {irq_en_reg, port_irq_flag_reg} <= IRQ_RST;
      end else begin
         if (ctl_wr) begin
            control_one_reg <= wdata[5:0];
         end
         if (sta_wr) begin
            sample_phase_reg <= wdata[STA_SMP];
            edge_sel_reg     <= wdata[STA_EDGE];
         end
         if (pg_wr) begin
            port_g_direction_reg <= wdata;
         end
         if (irq_wr) begin
            irq_en_reg <= wdata[IRQ_EN];
         end
         write_collision_flag_reg <= write_collision_flag_set || (write_collision_flag_reg && !(ctl_wr && !wdata[CTL_WRITE_COLLISION_FLAG]));
         port_irq_flag_reg <= done_ev || (port_irq_flag_reg && !(irq_wr && wdata[IRQ_FLAG]));
      end
   end

   // Received byte handling and the full flag.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data_buffer_reg      <= 8'h00;
         shift_register_reg   <= 8'h00;
         buffer_full_flag_reg <= 1'b0;
      end else begin
         if (samp_ev) begin
            shift_register_reg <= rx_next;
         end
         if (done_ev) begin
            data_buffer_reg <= done_val;
         end
         buffer_full_flag_reg <= done_ev || (buffer_full_flag_reg && !buf_rd);
      end
   end

   // Transmit side: with edge select set the first bit is put out at load.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_shift_reg <= 8'h00;
         out_bit_reg  <= 1'b0;
      end else if (load) begin
         tx_shift_reg <= edge_sel_reg ? {wdata[6:0], 1'b0} : wdata;
         out_bit_reg  <= edge_sel_reg ? wdata[7] : out_bit_reg;
      end else if (shift_ev) begin
         out_bit_reg  <= tx_shift_reg[7];
         tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
      end
   end

   // Master sequencer; the clock sits at the idle level outside a byte.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= SPM_IDLE;
         slot_reg  <= 5'h00;
         half_reg  <= 6'h00;
         sck_reg   <= 1'b0;
      end else if (port_reset || !is_master || (running && m_done)) begin
         state_reg <= SPM_IDLE;
         slot_reg  <= 5'h00;
         half_reg  <= 6'h00;
         sck_reg   <= clock_idle_polarity;
      end else if (!running) begin
         state_reg <= start ? SPM_RUN : SPM_IDLE;
         sck_reg   <= clock_idle_polarity;
      end else if (!sleep_mode) begin
         half_reg <= tick ? 6'h00 : half_reg + 6'h01;
         if (tick) begin
            slot_reg <= slot_reg + 5'h01;
            sck_reg  <= !sck_reg;
         end
      end
   end

   // Slave bit counter, cleared whenever the port resets.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bcnt_reg     <= 3'h0;
         sck_prev_reg <= 1'b0;
      end else begin
         sck_prev_reg <= serial_clk_in;
         if (port_reset || !is_slave) begin
            bcnt_reg <= 3'h0;
         end else if (s_cap) begin
            bcnt_reg <= bcnt_reg + 3'h1;
         end
      end
   end

   // Output flip-flops for pins, read data and wake request.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg  <= 8'h00;
         sdo_reg    <= 1'b0;
         sdo_oe_reg <= 1'b0;
         sck_o_reg  <= 1'b0;
         sck_oe_reg <= 1'b0;
         wake_reg   <= 1'b0;
      end else begin
         rdata_reg  <= rd_strobe ? rd_mux : 8'h00;
         sdo_reg    <= od ? 1'b0 : out_bit_reg;
         sdo_oe_reg <= sdo_drive && (od ? !out_bit_reg : 1'b1);
         sck_o_reg  <= od ? 1'b0 : sck_reg;
         sck_oe_reg <= is_master && (od ? !sck_reg : 1'b1);
         wake_reg   <= port_irq_flag_reg && irq_en_reg;
      end
   end

   assign rdata             = rdata_reg;
   assign serial_out_pin    = sdo_reg;
   assign serial_out_pin_oe = sdo_oe_reg;
   assign serial_clk_out    = sck_o_reg;
   assign serial_clk_oe     = sck_oe_reg;
   assign wake_req          = wake_reg;

   // ----------------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------------
   property p_start_runs;
      @(posedge clk) disable iff (!rst_n) start |=> running;
   endproperty
   a_start_runs: assert property (p_start_runs) else $error("Master write did not start a byte.");

   property p_first_bit;
      @(posedge clk) disable iff (!rst_n) (load && edge_sel_reg) |=> out_bit_reg == $past(wdata[7]);
   endproperty
   a_first_bit: assert property (p_first_bit) else $error("First bit not presented at load.");

   property p_collision;
      @(posedge clk) disable iff (!rst_n)
         (buf_wr && busy && !shift_ev) |=> write_collision_flag_reg && $stable(tx_shift_reg);
   endproperty
   a_collision: assert property (p_collision) else $error("Busy write not flagged or not discarded.");

   property p_full_flag;
      @(posedge clk) disable iff (!rst_n) done_ev |=> buffer_full_flag_reg && port_irq_flag_reg;
   endproperty
   a_full_flag: assert property (p_full_flag) else $error("Completed byte did not set the flags.");

   property p_idle_clock;
      @(posedge clk) disable iff (!rst_n)
         (is_master && !running && $past(!running) && $stable(clock_idle_polarity)) |-> sck_reg == clock_idle_polarity;
   endproperty
   a_idle_clock: assert property (p_idle_clock) else $error("Master clock not at idle level.");

   property p_open_drain;
      @(posedge clk) disable iff (!rst_n) $past(od) |-> !(serial_out_pin_oe && serial_out_pin) && !(serial_clk_oe && serial_clk_out);
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("Open drain pin driven high.");

   property p_select_release;
      @(posedge clk) disable iff (!rst_n) (port_enable_bit && ss_block) |=> !serial_out_pin_oe;
   endproperty
   a_select_release: assert property (p_select_release) else $error("Output still driven after select rose.");

   property p_select_reset;
      @(posedge clk) disable iff (!rst_n) port_reset |=> bcnt_reg == 3'h0 && !running;
   endproperty
   a_select_reset: assert property (p_select_reset) else $error("Port reset left the counter running.");

   property p_sleep_freeze;
      @(posedge clk) disable iff (!rst_n) (running && sleep_mode && !port_reset && is_master) |=> $stable(slot_reg) && $stable(sck_reg);
   endproperty
   a_sleep_freeze: assert property (p_sleep_freeze) else $error("Transfer moved during sleep.");

   property p_wake;
      @(posedge clk) disable iff (!rst_n) (done_ev && irq_en_reg && !irq_wr) |=> ##1 wake_req;
   endproperty
   a_wake: assert property (p_wake) else $error("Completion did not raise wake.");

endmodule

`default_nettype wire

// >>> logic/spm_pkg.sv
// Constants shared by the serial port: register offsets, field positions,
// reset values, mode codes and clock divider figures.
// Assumes a byte-wide register port with a three-bit word address.
package spm_pkg;

   // ----------------------------------------------------------------------
   // Register map.
   // ----------------------------------------------------------------------
   localparam int          ADDR_W           = 3;
   localparam logic [2:0]  OFF_DATA_BUFFER  = 3'h0;
   localparam logic [2:0]  OFF_CONTROL_ONE  = 3'h1;
   localparam logic [2:0]  OFF_STATUS_WORD  = 3'h2;
   localparam logic [2:0]  OFF_PORT_G_DIR   = 3'h3;
   localparam logic [2:0]  OFF_IRQ_CONTROL  = 3'h4;

   // ----------------------------------------------------------------------
   // Field positions.
   // ----------------------------------------------------------------------
   localparam int CTL_WRITE_COLLISION_FLAG    = 7;   // Write collision flag.
   localparam int CTL_EN      = 5;   // Port enable bit.
   localparam int CTL_CKP     = 4;   // Clock idle polarity.
   localparam int STA_SMP     = 7;   // Sample phase.
   localparam int STA_EDGE    = 6;   // Clock edge select.
   localparam int STA_BF      = 0;   // Buffer full flag.
   localparam int PG_OD       = 7;   // Open drain select.
   localparam int PG_SDO_DIR  = 0;   // Serial out pin direction, 1 is input.
   localparam int IRQ_FLAG    = 0;   // Port irq flag, write one to clear.
   localparam int IRQ_EN      = 1;   // Port irq enable.

   // ----------------------------------------------------------------------
   // Reset values.
   // ----------------------------------------------------------------------
   localparam logic [7:0] CTL_RST = 8'h00;
   localparam logic [1:0] STA_RST = 2'h0;
   localparam logic [7:0] PG_RST  = 8'h7F;
   localparam logic [1:0] IRQ_RST = 2'h0;

   // ----------------------------------------------------------------------
   // Mode field codes.
   // ----------------------------------------------------------------------
   localparam logic [3:0] MODE_DIV4   = 4'h0;
   localparam logic [3:0] MODE_DIV16  = 4'h1;
   localparam logic [3:0] MODE_DIV64  = 4'h2;
   localparam logic [3:0] MODE_TMR2   = 4'h3;
   localparam logic [3:0] MODE_SLV_SS = 4'h4;
   localparam logic [3:0] MODE_SLV    = 4'h5;

   // ----------------------------------------------------------------------
   // Master clock divisors and the half period counts derived from them.
   // ----------------------------------------------------------------------
   localparam int         DIV_A      = 4;
   localparam int         DIV_B      = 16;
   localparam int         DIV_C      = 64;
   localparam logic [5:0] HALF_A     = 6'(DIV_A / 2);
   localparam logic [5:0] HALF_B     = 6'(DIV_B / 2);
   localparam logic [5:0] HALF_C     = 6'(DIV_C / 2);
   localparam logic [4:0] LAST_SLOT  = 5'h10;
   localparam logic [2:0] LAST_BIT   = 3'h7;

   typedef enum logic {SPM_IDLE, SPM_RUN} spm_state_t;

endpackage

// >>> dv/spm_slave_model.sv
// Behavioural SPI slave that answers the port while it runs as master.
// Assumes the bench resolves the wires and selects the model for each byte.
`timescale 1ns/1ps
`default_nettype none
module spm_slave_model (
   // Serial wires.
   input  wire logic       sclk,
   input  wire logic       mosi,
   output logic            miso,
   // Set-up from the bench.
   input  wire logic       cs_n,
   input  wire logic       cpol,
   input  wire logic       cpha,
   input  wire logic [7:0] tx_byte,
   output logic [7:0]      rx_byte
);
   logic [7:0] sh = 8'h00;
   logic       lead;
   initial miso = 1'b0;
   initial rx_byte = 8'h00;
   // Selecting loads the byte; a released line shows the inverse of its last bit.
   always @(negedge cs_n) begin
      sh = tx_byte;
      miso = cpha ? ~miso : tx_byte[7];
   end
   always @(posedge cs_n) miso = ~miso;
   // Capture on one edge, shift on the other, most significant bit first.
   always @(sclk) begin
      lead = (sclk !== cpol);
      if (!cs_n && (lead ^ cpha)) begin
         rx_byte = {rx_byte[6:0], mosi};
      end else if (!cs_n) begin
         if (!cpha) sh = sh << 1;
         miso = sh[7];
         if (cpha) sh = sh << 1;
      end
   end
endmodule
`default_nettype wire

// >>> dv/spm_port_test.sv
// Self-checking bench for the serial port: register reads, master bytes, slave select.
// Assumes the slave model from the same folder; open wires are pulled high.
`timescale 1ns/1ps
`default_nettype none
module spm_port_test;
   import spm_pkg::*;
   logic       clk = 1'b0, rst_n = 1'b0, wr_strobe = 1'b0, rd_strobe = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00, rdata, m_rx, s_tx = 8'h00;
   logic       s_out, s_oe, c_out, c_oe, wake_req, miso, rd_seen = 1'b0;
   logic       select_n = 1'b1, sleep_mode = 1'b0, timer2_tick = 1'b0, cs_n = 1'b1;
   logic       cfg_p = 1'b0, cfg_h = 1'b0, oe_seen = 1'b0, hi_seen = 1'b0;
   logic [1:0] tcnt = 2'h0;
   logic [7:0] exp_q[$];
   int         bad_count = 0, total_checks = 0, seed = 32'h855b;
   wire        sclk_w = c_oe ? c_out : 1'b1;
   wire        mosi_w = s_oe ? s_out : 1'b1;
   spm_port i_spm_port (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
      .rd_strobe(rd_strobe), .rdata(rdata), .serial_in_pin(miso), .serial_out_pin(s_out),
      .serial_out_pin_oe(s_oe), .serial_clk_in(sclk_w), .serial_clk_out(c_out), .serial_clk_oe(c_oe),
      .select_n(select_n), .sleep_mode(sleep_mode), .timer2_tick(timer2_tick), .wake_req(wake_req));
   spm_slave_model i_spm_slave_model (.sclk(sclk_w), .mosi(mosi_w), .miso(miso), .cs_n(cs_n),
      .cpol(cfg_p), .cpha(cfg_h), .tx_byte(s_tx), .rx_byte(m_rx));
   // ---------------------------------------------------------------------
   // Clock, timer ticks every third cycle so half periods never collapse.
   // ---------------------------------------------------------------------
   always #20 clk = ~clk;
   always @(posedge clk) begin
      tcnt <= (tcnt == 2'h2) ? 2'h0 : tcnt + 2'h1;
      timer2_tick <= (tcnt == 2'h2);
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Read data stands one cycle only, so the oldest note is taken right then.
   always @(posedge clk) begin
      rd_seen <= rd_strobe;
      if (rd_seen) chk(rdata, exp_q.pop_front());
      if (s_oe) oe_seen <= 1'b1;
      if (s_out | c_out) hi_seen <= 1'b1;
   end
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      addr <= a; wdata <= d; wr_strobe <= 1'b1;
      @(posedge clk); wr_strobe <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      addr <= a; rd_strobe <= 1'b1;
      @(posedge clk); rd_strobe <= 1'b0;
      @(posedge clk);
   endtask
   // One master byte: set-up, start, a discarded busy write, then the results.
   task automatic xfer(input logic [3:0] m, input logic p, input logic e, input logic [7:0] pg);
      logic [7:0] t;
      logic       s0;
      int         n;
      t = 8'($random(seed));
      s_tx = 8'($random(seed));
      cfg_p = p; cfg_h = ~e;
      wr(OFF_CONTROL_ONE, {2'b00, 1'b1, p, m});
      wr(OFF_STATUS_WORD, {1'b0, e, 6'h00});
      wr(OFF_PORT_G_DIR, pg);
      wr(OFF_IRQ_CONTROL, 8'h02);
      cs_n <= 1'b0;
      oe_seen = 1'b0; hi_seen = 1'b0;
      wr(OFF_DATA_BUFFER, t);
      wr(OFF_DATA_BUFFER, ~t);
      if (m == MODE_DIV16) begin
         repeat (30) @(posedge clk);
         sleep_mode <= 1'b1;
         repeat (3) @(posedge clk);
         s0 = sclk_w;
         repeat (20) @(posedge clk);
         chk({7'h0, sclk_w}, {7'h0, s0});
         sleep_mode <= 1'b0;
      end
      n = 0;
      while (wake_req !== 1'b1 && n < 4000) begin @(posedge clk); n++; end
      chk({7'h0, wake_req}, 8'h01);
      chk({7'h0, sclk_w}, {7'h0, p});
      chk({7'h0, oe_seen}, {7'h0, ~pg[0]});
      if (pg[7]) chk({7'h0, hi_seen}, 8'h00);
      if (!pg[0]) chk(m_rx, t);
      rd(OFF_CONTROL_ONE, {2'b10, 1'b1, p, m});
      rd(OFF_STATUS_WORD, {1'b0, e, 5'h00, 1'b1});
      rd(OFF_DATA_BUFFER, s_tx);
      rd(OFF_STATUS_WORD, {1'b0, e, 6'h00});
      rd(OFF_IRQ_CONTROL, 8'h03);
      wr(OFF_IRQ_CONTROL, 8'h01);
      repeat (2) @(posedge clk);
      chk({7'h0, wake_req}, 8'h00);
      cs_n <= 1'b1;
      wr(OFF_CONTROL_ONE, 8'h00);
   endtask
   task automatic summarize();
      if (bad_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #2_000_000;
      bad_count++;
      summarize();
   end
   // ---------------------------------------------------------------------
   // Main sequence.
   // ---------------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(OFF_CONTROL_ONE, CTL_RST);
      rd(OFF_STATUS_WORD, 8'h00);
      rd(OFF_PORT_G_DIR, PG_RST);
      rd(OFF_IRQ_CONTROL, 8'h00);
      wr(3'h5, 8'hFF);
      rd(3'h5, 8'h00);
      xfer(MODE_DIV4, 1'b0, 1'b1, 8'h00);
      xfer(MODE_DIV16, 1'b0, 1'b0, 8'h00);
      xfer(MODE_DIV64, 1'b1, 1'b1, 8'h00);
      xfer(MODE_TMR2, 1'b1, 1'b0, 8'h00);
      xfer(MODE_DIV4, 1'b0, 1'b1, PG_RST);
      xfer(MODE_DIV4, 1'b1, 1'b1, 8'h80);
      // Slave with select: clock idles high to match the pull-up.
      wr(OFF_PORT_G_DIR, 8'h00);
      wr(OFF_CONTROL_ONE, 8'h34);
      select_n <= 1'b0;
      repeat (3) @(posedge clk);
      chk({7'h0, s_oe}, 8'h01);
      select_n <= 1'b1;
      repeat (2) @(posedge clk);
      chk({7'h0, s_oe}, 8'h00);
      summarize();
   end
endmodule
`default_nettype wire
